// [logic/hpsip_led_drv.sv]
// Per-port indicator LED polarity and drive stage
module hpsip_led_drv
   import hpsip_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control
   input wire logic led_enable,
   input wire logic [HPSIP_PORTS-1:0] led_on,
   input wire logic [HPSIP_PORTS-1:0] active_low,
   input wire logic run,
   // Pad
   output logic [HPSIP_PORTS-1:0] led_out,
   output logic [HPSIP_PORTS-1:0] led_oe
);
   genvar i;
   generate
      for (i = 0; i < HPSIP_PORTS; i++) begin : g_led
         // Pad stays undriven until straps are captured, else the LED
         // drive would corrupt the strap level being sampled.
         always_ff @(posedge clk) begin
            if (rst) begin
               led_out[i] <= 1'b0;
               led_oe[i] <= 1'b0;
            end else begin
               led_oe[i] <= run & led_enable;
               led_out[i] <= led_on[i] ^ active_low[i];
            end
         end
      end
   endgenerate
endmodule

// [logic/hpsip_pkg.sv]
// Constants and types shared by the hub port strap and indicator pin logic
package hpsip_pkg;
   localparam int HPSIP_PORTS = 7;
   // Avalon-MM register word addresses (byte address = word * 4)
   localparam logic [3:0] HPSIP_REG_CTRL = 4'h0;
   localparam logic [3:0] HPSIP_REG_PWR = 4'h1;
   localparam logic [3:0] HPSIP_REG_LED = 4'h2;
   localparam logic [3:0] HPSIP_REG_STRAP = 4'h3;
   localparam logic [3:0] HPSIP_REG_STATUS = 4'h4;
   // Control register fields
   localparam int HPSIP_CTRL_DIS_EN = 0;
   localparam int HPSIP_CTRL_SWP_EN = 1;
   localparam int HPSIP_CTRL_LED_EN = 2;
   localparam int HPSIP_CTRL_CONN_EN = 3;
   localparam logic [3:0] HPSIP_CTRL_RESET = 4'hF;
   // Strap register fields
   localparam int HPSIP_STRAP_SWP_LSB = 8;
   // Status register fields
   localparam int HPSIP_STAT_VBUS = 0;
   localparam int HPSIP_STAT_PULLUP = 1;
   localparam int HPSIP_STAT_DONE = 2;
   // Settle cycles, after one reset-exit cycle, before strap capture, lets pads settle
   localparam logic [3:0] HPSIP_STRAP_DELAY = 4'h4;
   localparam logic [31:0] HPSIP_UNMAPPED = 32'h00000000;
   typedef enum logic [2:0] {
      HPSIP_IN_RESET = 3'b001,
      HPSIP_SETTLE = 3'b010,
      HPSIP_RUN = 3'b100
   } hpsip_state_e;
endpackage

// [logic/hpsip_top.sv]
// Hub port strap capture, power enable and indicator pin logic
// Contract
// - Pins named with low-active suffix assert low; all others assert high.
// - Upstream power detect decides when the D+ connect pull-up is enabled.
// - With disable strap enabled, high port strap at reset release disables port.
// - Port power enables are driven high to power a port.
// - Indicator LEDs for ports one to seven drive with the polarity the swap strap picks when enabled.
// - With swap strap enabled, indicator pin sampled at release picks polarity.
// - Swap strap zero: normal polarity, LED active high.
// - Swap strap one: data pins exchanged, LED active low.
//
// The implementer's own choices: the Avalon-MM register port and the register offsets.
module hpsip_top
   import hpsip_pkg::*;
(
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // Avalon-MM slave
   input wire logic [3:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // Upstream
   input wire logic UPSTREAM_POWER_DETECT,
   output logic UPSTREAM_PULLUP_EN,
   // Downstream strap pins
   input wire logic [HPSIP_PORTS-1:0] PORT_DISABLE_STRAP_PLUS,
   input wire logic [HPSIP_PORTS-1:0] PORT_DISABLE_STRAP_MINUS,
   // Indicator pins, also polarity swap straps
   input wire logic [HPSIP_PORTS-1:0] PORT_INDICATOR_LED_IN,
   output logic [HPSIP_PORTS-1:0] PORT_INDICATOR_LED_OUT,
   output logic [HPSIP_PORTS-1:0] PORT_INDICATOR_LED_OE,
   // Port control
   output logic [HPSIP_PORTS-1:0] PORT_POWER_ENABLE,
   output logic [HPSIP_PORTS-1:0] PORT_DISABLED,
   output logic [HPSIP_PORTS-1:0] PORT_POLARITY_SWAPPED
);
   hpsip_state_e state;
   logic [3:0] settle_cnt;
   logic [3:0] ctrl;
   logic [HPSIP_PORTS-1:0] pwr_req;
   logic [HPSIP_PORTS-1:0] led_req;
   logic [HPSIP_PORTS-1:0] dis_strap;
   logic [HPSIP_PORTS-1:0] swp_strap;
   logic [31:0] next_rdata;
   logic ack;
   logic run;
   logic req;
   logic capture;
   logic wr_commit;

   assign run = (state == HPSIP_RUN);
   assign req = AVS_READ | AVS_WRITE;

   // Straps are read on the last settle cycle, once per reset
   assign capture = (state == HPSIP_SETTLE) &&
                    (settle_cnt == HPSIP_STRAP_DELAY - 4'h1);

   // A write commits only on the edge at which waitrequest is seen low
   assign wr_commit = AVS_WRITE & ack;

   // Strap capture sequencing after reset release. The pads get a few
   // cycles to settle first; ctrl writes in that time still count.
   always_ff @(posedge MCLK) begin
      if (RST) begin
         state <= HPSIP_IN_RESET;
         settle_cnt <= 4'h0;
      end else begin
         case (state)
            HPSIP_IN_RESET: begin
               state <= HPSIP_SETTLE;
               settle_cnt <= 4'h0;
            end
            HPSIP_SETTLE: begin
               settle_cnt <= settle_cnt + 4'h1;
               if (capture) begin
                  state <= HPSIP_RUN;
               end
            end
            HPSIP_RUN: begin
               state <= HPSIP_RUN;
            end
            default: begin
               state <= HPSIP_IN_RESET;
            end
         endcase
      end
   end

   // One capture stage and one set of pin flops per port
   genvar p;
   generate
      for (p = 0; p < HPSIP_PORTS; p++) begin : g_port
         // Straps taken once on leaving settle, then frozen until reset
         always_ff @(posedge MCLK) begin
            if (RST) begin
               dis_strap[p] <= 1'b0;
               swp_strap[p] <= 1'b0;
            end else if (capture) begin
               if (ctrl[HPSIP_CTRL_DIS_EN]) begin
                  // Either strap leg pulled high marks the port disabled
                  dis_strap[p] <= PORT_DISABLE_STRAP_PLUS[p] |
                                  PORT_DISABLE_STRAP_MINUS[p];
               end
               if (ctrl[HPSIP_CTRL_SWP_EN]) begin
                  swp_strap[p] <= PORT_INDICATOR_LED_IN[p];
               end
            end
         end

         // Registered port pins. Power waits for run, so a port whose
         // strap says disabled is never powered, not even for a cycle.
         always_ff @(posedge MCLK) begin
            if (RST) begin
               PORT_POWER_ENABLE[p] <= 1'b0;
               PORT_DISABLED[p] <= 1'b0;
               PORT_POLARITY_SWAPPED[p] <= 1'b0;
            end else begin
               PORT_POWER_ENABLE[p] <= run & pwr_req[p] &
                                       ~dis_strap[p];
               PORT_DISABLED[p] <= dis_strap[p];
               PORT_POLARITY_SWAPPED[p] <= swp_strap[p];
            end
         end
      end
   endgenerate

   // Connect pull-up follows the upstream power detect level
   always_ff @(posedge MCLK) begin
      if (RST) begin
         UPSTREAM_PULLUP_EN <= 1'b0;
      end else begin
         UPSTREAM_PULLUP_EN <= run & ctrl[HPSIP_CTRL_CONN_EN] &
                               UPSTREAM_POWER_DETECT;
      end
   end

   // Register writes; byte lane 0 carries every field. Writes to the
   // strap and status words and to unmapped words are dropped.
   always_ff @(posedge MCLK) begin
      if (RST) begin
         ctrl <= HPSIP_CTRL_RESET;
         pwr_req <= '0;
         led_req <= '0;
      end else if (wr_commit) begin
         if (AVS_ADDRESS == HPSIP_REG_CTRL) begin
            if (AVS_BYTEENABLE[0]) begin
               ctrl <= AVS_WRITEDATA[3:0];
            end
         end else if (AVS_ADDRESS == HPSIP_REG_PWR) begin
            if (AVS_BYTEENABLE[0]) begin
               pwr_req <= AVS_WRITEDATA[HPSIP_PORTS-1:0];
            end
         end else if (AVS_ADDRESS == HPSIP_REG_LED) begin
            if (AVS_BYTEENABLE[0]) begin
               led_req <= AVS_WRITEDATA[HPSIP_PORTS-1:0];
            end
         end
      end
   end

   // Read mux; unmapped addresses read zero
   // Status shows the detect pin live, so it may lead the pull-up bit
   always_comb begin
      next_rdata = HPSIP_UNMAPPED;
      if (AVS_ADDRESS == HPSIP_REG_CTRL) begin
         next_rdata[3:0] = ctrl;
      end else if (AVS_ADDRESS == HPSIP_REG_PWR) begin
         next_rdata[HPSIP_PORTS-1:0] = pwr_req;
      end else if (AVS_ADDRESS == HPSIP_REG_LED) begin
         next_rdata[HPSIP_PORTS-1:0] = led_req;
      end else if (AVS_ADDRESS == HPSIP_REG_STRAP) begin
         next_rdata[HPSIP_PORTS-1:0] = dis_strap;
         next_rdata[HPSIP_STRAP_SWP_LSB +: HPSIP_PORTS] = swp_strap;
      end else if (AVS_ADDRESS == HPSIP_REG_STATUS) begin
         next_rdata[HPSIP_STAT_VBUS] = UPSTREAM_POWER_DETECT;
         next_rdata[HPSIP_STAT_PULLUP] = UPSTREAM_PULLUP_EN;
         next_rdata[HPSIP_STAT_DONE] = run;
      end
   end

   // One wait cycle per access: request seen, then completed. Read data
   // is loaded on the taking edge so it stands at the completion edge.
   always_ff @(posedge MCLK) begin
      if (RST) begin
         ack <= 1'b0;
         AVS_READDATA <= '0;
      end else begin
         ack <= req & ~ack;
         if (AVS_READ && !ack) begin
            AVS_READDATA <= next_rdata;
         end
      end
   end

   // Waitrequest is high except in the completion cycle
   // Registered, so every request sees exactly one wait edge
   always_ff @(posedge MCLK) begin
      if (RST) begin
         AVS_WAITREQUEST <= 1'b1;
      end else begin
         AVS_WAITREQUEST <= ~(req & ~ack);
      end
   end

   // Swap strap one gives active-low LEDs; the LED enable bit drives pads
   // Disabled ports hold their LED at the off level
   hpsip_led_drv u_led (
      .clk(MCLK),
      .rst(RST),
      .led_enable(ctrl[HPSIP_CTRL_LED_EN]),
      .led_on(led_req & ~dis_strap),
      .active_low(swp_strap),
      .run(run),
      .led_out(PORT_INDICATOR_LED_OUT),
      .led_oe(PORT_INDICATOR_LED_OE)
   );
endmodule

// [testbench/hpsip_chk.sv]
// Assertion checker for the hub port strap and indicator pins
module hpsip_chk
   import hpsip_pkg::*;
(
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // Bus handshake
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic AVS_WAITREQUEST,
   // Pins
   input wire logic UPSTREAM_POWER_DETECT,
   input wire logic UPSTREAM_PULLUP_EN,
   input wire logic [HPSIP_PORTS-1:0] PORT_INDICATOR_LED_OUT,
   input wire logic [HPSIP_PORTS-1:0] PORT_INDICATOR_LED_OE,
   input wire logic [HPSIP_PORTS-1:0] PORT_POWER_ENABLE,
   input wire logic [HPSIP_PORTS-1:0] PORT_DISABLED,
   input wire logic [HPSIP_PORTS-1:0] PORT_POLARITY_SWAPPED
);
   // Cycles since reset release, saturating
   logic [3:0] age;
   always_ff @(posedge MCLK) begin
      if (RST) age <= 4'h0;
      else if (age != 4'hF) age <= age + 4'h1;
   end
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);
   a_pwr_gate: assert property (
      ~|(PORT_POWER_ENABLE & PORT_DISABLED)) else $error("disabled powered");
   a_pwr_early: assert property (
      age <= 4'h4 |-> ~|PORT_POWER_ENABLE) else $error("early power");
   a_pullup_off: assert property (
      !UPSTREAM_POWER_DETECT |=> !UPSTREAM_PULLUP_EN) else $error("pullup");
   a_pullup_early: assert property (
      age <= 4'h4 |-> !UPSTREAM_PULLUP_EN) else $error("early pullup");
   // Pad must stay released while it is being read as a strap
   a_led_quiet: assert property (
      age <= 4'h4 |-> ~|PORT_INDICATOR_LED_OE) else $error("led drive");
   a_straps_hold: assert property (
      age >= 4'h8 |-> $stable(PORT_DISABLED) && $stable(PORT_POLARITY_SWAPPED))
      else $error("strap moved");
   a_led_offlevel: assert property (
      age >= 4'h8 |-> ~|((PORT_INDICATOR_LED_OUT ^ PORT_POLARITY_SWAPPED)
      & PORT_DISABLED & PORT_INDICATOR_LED_OE)) else $error("led level");
   a_bus_answer: assert property (
      $rose(AVS_READ || AVS_WRITE) |=> !AVS_WAITREQUEST) else $error("no ack");
endmodule

bind hpsip_top hpsip_chk chk (.MCLK, .RST, .AVS_READ, .AVS_WRITE,
   .AVS_WAITREQUEST, .UPSTREAM_POWER_DETECT, .UPSTREAM_PULLUP_EN,
   .PORT_INDICATOR_LED_OUT, .PORT_INDICATOR_LED_OE, .PORT_POWER_ENABLE,
   .PORT_DISABLED, .PORT_POLARITY_SWAPPED);

// [testbench/hpsip_far.sv]
// Board side model: strap resistors on the shared indicator pads
module hpsip_far
   import hpsip_pkg::*;
(
   // Strap resistor levels
   input wire logic [HPSIP_PORTS-1:0] pull,
   // Device drive
   input wire logic [HPSIP_PORTS-1:0] drv,
   input wire logic [HPSIP_PORTS-1:0] oe,
   // Resolved pad
   output logic [HPSIP_PORTS-1:0] pad
);
   // Released pads fall back to their resistor, not the last driven value
   assign pad = (drv & oe) | (pull & ~oe);
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the hub port strap and indicator pins
module tb_top
   import hpsip_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk, rst, rd, wr, det, pu, wreq;
   logic [3:0] adr, be;
   logic [31:0] wd, rdat, q;
   logic [6:0] dp, dm, pull, pad, lo, loe, pwr, dis, swp;
   int mismatches, n_tests;
   hpsip_top dut (.MCLK(mclk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be),
      .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
      .UPSTREAM_POWER_DETECT(det), .UPSTREAM_PULLUP_EN(pu),
      .PORT_DISABLE_STRAP_PLUS(dp), .PORT_DISABLE_STRAP_MINUS(dm),
      .PORT_INDICATOR_LED_IN(pad), .PORT_INDICATOR_LED_OUT(lo),
      .PORT_INDICATOR_LED_OE(loe), .PORT_POWER_ENABLE(pwr),
      .PORT_DISABLED(dis), .PORT_POLARITY_SWAPPED(swp));
   hpsip_far far (.pull(pull), .drv(lo), .oe(loe), .pad(pad));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One bus access; read data is left in q
   // Waits as long as the answer takes; the watchdog ends a hang
   task automatic acc(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
      @(posedge mclk);
      wr <= w;
      rd <= !w;
      adr <= a;
      wd <= d;
      do begin
         @(posedge mclk);
      end while (wreq !== 1'b0);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic reset_dut();
      rst <= 1'b1;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      #200000;
      mismatches++;
      conclude();
   end
   initial begin
      rst = 1'b1;
      rd = 1'b0;
      wr = 1'b0;
      adr = 4'h0;
      be = 4'h1;
      wd = 32'h0;
      det = 1'b1;
      dp = 7'h01;
      dm = 7'h40;
      pull = 7'h0A;
      reset_dut();
      repeat (8) @(posedge mclk);
      chk(dis, 7'h41);
      chk(swp, 7'h0A);
      acc(1'b0, HPSIP_REG_STRAP, 32'h0);
      chk(q, 32'h00000A41);
      acc(1'b1, HPSIP_REG_PWR, 32'h7F);
      acc(1'b1, HPSIP_REG_LED, 32'h7F);
      dp <= 7'h00;
      dm <= 7'h00;
      pull <= 7'h75;
      det <= 1'b0;
      repeat (2) @(posedge mclk);
      chk(pwr, 7'h3E);
      chk(loe, 7'h7F);
      chk(lo, 7'h34);
      chk({dis, swp}, 14'h208A);
      chk(pu, 1'b0);
      det <= 1'b1;
      repeat (2) @(posedge mclk);
      chk(pu, 1'b1);
      acc(1'b0, HPSIP_REG_STATUS, 32'h0);
      chk(q, 32'h7);
      acc(1'b0, 4'hF, 32'h0);
      chk(q, HPSIP_UNMAPPED);
      $display("test straps enabled done");
      dp <= 7'h7F;
      reset_dut();
      acc(1'b1, HPSIP_REG_CTRL, 32'h4);
      acc(1'b1, HPSIP_REG_LED, 32'h05);
      be <= 4'h0;
      acc(1'b1, HPSIP_REG_LED, 32'h7F);
      be <= 4'h1;
      acc(1'b0, HPSIP_REG_LED, 32'h0);
      chk(q, 32'h00000005);
      repeat (8) @(posedge mclk);
      chk({dis, swp}, 14'h0);
      chk(lo, 7'h05);
      chk(pu, 1'b0);
      acc(1'b1, HPSIP_REG_CTRL, 32'h0);
      repeat (2) @(posedge mclk);
      chk(loe, 7'h00);
      $display("test straps disabled done");
      conclude();
   end
endmodule
